// >>> hdl/prbs_delay_gen.sv
// delayed-tap sequence generator with gate timing and axi4-lite registers
`timescale 1ns/100ps
module prbs_delay_gen
  import prbs_pkg::*;
#(
  parameter int UNIT_CYCLES = US_CYCLES
) (
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite write
  input  wire logic [5:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [5:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // pins and contacts
  input  wire logic        ext_clk_pin,
  input  wire logic        remote_sel,
  input  wire settings_t   remote_set,
  input  wire logic        remote_arm,
  input  wire logic        gate_reset_btn,
  // sequence outputs
  output logic             prbs_o,
  output logic             delayed_o,
  output logic             sync_o,
  output logic             gate_o,
  output logic             relay_o,
  output logic             gate_reset_short_o
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  settings_t   rset_s1_ff, rset_s2_ff;
  logic [2:0]  pin_s1_ff, pin_s2_ff, nxt_pin_s1;
  logic        arm_old_ff;

  always_comb begin
    nxt_pin_s1 = {remote_sel, remote_arm, gate_reset_btn};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rset_s1_ff <= '0;
      rset_s2_ff <= '0;
      pin_s1_ff  <= 3'h0;
      pin_s2_ff  <= 3'h0;
      arm_old_ff <= 1'b0;
    end else if (ce) begin
      rset_s1_ff <= remote_set;
      rset_s2_ff <= rset_s1_ff;
      pin_s1_ff  <= nxt_pin_s1;
      pin_s2_ff  <= pin_s1_ff;
      arm_old_ff <= pin_s2_ff[1];
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite slave and registers
  // ---------------------------------------------------------------
  logic [31:0] ctrl_ff, nxt_ctrl, delay_ff, nxt_delay, rdata_ff, nxt_rdata;
  logic [5:0]  awa_ff, nxt_awa;
  logic [31:0] wd_ff, nxt_wd;
  logic [3:0]  ws_ff, nxt_ws;
  logic        awg_ff, nxt_awg, wg_ff, nxt_wg, awr_ff, nxt_awr, wr_ff, nxt_wr;
  logic        bv_ff, nxt_bv, arr_ff, nxt_arr, rv_ff, nxt_rv;
  logic [1:0]  br_ff, nxt_br, rr_ff, nxt_rr;
  logic        do_wr, sw_arm, tbl_we;
  logic [5:0]  wa;
  logic [31:0] wd;
  logic [3:0]  ws;
  logic [19:0] pos_ff, nxt_pos;
  gate_state_t gst_ff, nxt_gst;
  settings_t   eff;
  logic        rnd_mode;

  always_comb begin
    nxt_awa   = (awvalid & awr_ff) ? awaddr : awa_ff;
    nxt_wd    = (wvalid & wr_ff) ? wdata : wd_ff;
    nxt_ws    = (wvalid & wr_ff) ? wstrb : ws_ff;
    wa        = nxt_awa;
    wd        = nxt_wd;
    ws        = nxt_ws;
    do_wr     = (awg_ff | (awvalid & awr_ff)) & (wg_ff | (wvalid & wr_ff)) & ~bv_ff;
    nxt_awg   = (awg_ff | (awvalid & awr_ff)) & ~do_wr;
    nxt_wg    = (wg_ff | (wvalid & wr_ff)) & ~do_wr;
    nxt_bv    = do_wr | (bv_ff & ~bready);
    nxt_awr   = ~nxt_awg & ~nxt_bv;
    nxt_wr    = ~nxt_wg & ~nxt_bv;
    nxt_br    = br_ff;
    nxt_ctrl  = ctrl_ff;
    nxt_ctrl[CTRL_ARM_BIT] = 1'b0;
    nxt_delay = delay_ff;
    tbl_we    = 1'b0;
    sw_arm    = 1'b0;
    if (do_wr) begin
      nxt_br = RESP_OKAY;
      unique case (wa)
        OFF_CTRL: begin
          nxt_ctrl = merge(ctrl_ff, wd, ws);
          nxt_ctrl[CTRL_ARM_BIT] = 1'b0;
          sw_arm   = ws[3] & wd[CTRL_ARM_BIT];
        end
        OFF_DELAY: nxt_delay = merge(delay_ff, wd, ws);
        OFF_TABLE: tbl_we    = &ws;
        default:   nxt_br    = RESP_SLVERR;
      endcase
    end
    nxt_rv    = (arvalid & arr_ff) | (rv_ff & ~rready);
    nxt_arr   = ~nxt_rv;
    nxt_rdata = rdata_ff;
    nxt_rr    = rr_ff;
    if (arvalid & arr_ff) begin
      nxt_rr = RESP_OKAY;
      unique case (araddr)
        OFF_CTRL:   nxt_rdata = ctrl_ff;
        OFF_DELAY:  nxt_rdata = delay_ff;
        OFF_STATUS: nxt_rdata = {24'h0, gst_ff, pin_s2_ff[2], rnd_mode, gate_o, sync_o, prbs_o};
        OFF_POS:    nxt_rdata = {12'h0, pos_ff};
        default: begin
          nxt_rdata = 32'h0;
          nxt_rr    = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff  <= CTRL_RST;
      delay_ff <= DELAY_RST;
      awa_ff   <= 6'h0;
      wd_ff    <= 32'h0;
      ws_ff    <= 4'h0;
      awg_ff   <= 1'b0;
      wg_ff    <= 1'b0;
      awr_ff   <= 1'b1;
      wr_ff    <= 1'b1;
      bv_ff    <= 1'b0;
      br_ff    <= RESP_OKAY;
      arr_ff   <= 1'b1;
      rv_ff    <= 1'b0;
      rr_ff    <= RESP_OKAY;
      rdata_ff <= 32'h0;
    end else if (ce) begin
      ctrl_ff  <= nxt_ctrl;
      delay_ff <= nxt_delay;
      awa_ff   <= nxt_awa;
      wd_ff    <= nxt_wd;
      ws_ff    <= nxt_ws;
      awg_ff   <= nxt_awg;
      wg_ff    <= nxt_wg;
      awr_ff   <= nxt_awr;
      wr_ff    <= nxt_wr;
      bv_ff    <= nxt_bv;
      br_ff    <= nxt_br;
      arr_ff   <= nxt_arr;
      rv_ff    <= nxt_rv;
      rr_ff    <= nxt_rr;
      rdata_ff <= nxt_rdata;
    end
  end

  assign awready = awr_ff;
  assign wready  = wr_ff;
  assign bvalid  = bv_ff;
  assign bresp   = br_ff;
  assign arready = arr_ff;
  assign rvalid  = rv_ff;
  assign rresp   = rr_ff;
  assign rdata   = rdata_ff;

  // ---------------------------------------------------------------
  // delay table, loaded by software for the length in use
  // ---------------------------------------------------------------
  tap_pair_t tap_tbl [TBL_DEPTH];

  always_ff @(posedge aclk) begin
    if (ce && tbl_we) begin
      tap_tbl[wd[TABLE_IDX_LSB +: 11]] <= tap_pair_t'(wd[10:0]);
    end
  end

  // ---------------------------------------------------------------
  // sequence clock
  // ---------------------------------------------------------------
  logic tick;

  always_comb begin
    eff      = pin_s2_ff[2] ? rset_s2_ff
               : settings_t'({ctrl_ff[CTRL_GLEN_LSB +: 2], ctrl_ff[CTRL_EXT_BIT],
                              ctrl_ff[CTRL_RATE_LSB +: 5], ctrl_ff[CTRL_LEN_LSB +: 5]});
    rnd_mode = (eff.len_sel >= LEN_RANDOM);
  end

  prbs_tick_gen #(
    .UNIT_CYCLES (UNIT_CYCLES)
  ) u_tick (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .ce          (ce),
    .rate_sel    (eff.rate_sel),
    .ext_sel     (eff.ext_clk),
    .ext_clk_pin (ext_clk_pin),
    .tick        (tick)
  );

  // ---------------------------------------------------------------
  // shift register, gate and outputs
  // ---------------------------------------------------------------
  logic [31:0] sr_ff, nxt_sr, rnd_ff, nxt_rnd;
  logic [4:0]  len_ff;
  logic [2:0]  gcnt_ff, nxt_gcnt;
  logic        dly_ff, nxt_dly, sync_ff, nxt_sync, gate_ff, nxt_gate;
  logic        relay_ff, nxt_relay, short_ff;
  logic        reload, restart, fb, tap_v, arm_req;
  tap_pair_t   pair;
  logic [2:0]  gate_last;

  always_comb begin
    reload   = (eff.len_sel != len_ff);
    restart  = tick & ~rnd_mode & (pos_ff == seq_last(eff.len_sel));
    fb       = ^(sr_ff[FB_STAGES-1:0] & tap_mask(eff.len_sel));
    nxt_rnd  = {rnd_ff[30:0], rnd_ff[31] ^ rnd_ff[21] ^ rnd_ff[1] ^ rnd_ff[0]};
    nxt_sr   = sr_ff;
    nxt_pos  = pos_ff;
    if (reload) begin
      nxt_sr  = SEED;
      nxt_pos = 20'h0;
    end else if (tick) begin
      nxt_sr  = {sr_ff[STAGES-2:0], rnd_mode ? rnd_ff[31] : fb};
      nxt_pos = restart ? 20'h0 : pos_ff + 20'h1;
    end
    pair     = tap_tbl[delay_ff[10:0]];
    if (delay_ff[DELAY_DIRECT_BIT]) begin
      tap_v = sr_ff[delay_ff[4:0]];
    end else begin
      tap_v = sr_ff[pair.stage_a] ^ (pair.use_b & sr_ff[pair.stage_b]);
    end
    nxt_dly   = rnd_mode ? 1'b0 : tap_v;
    nxt_relay = (~eff.ext_clk & (period_thirds(eff.rate_sel) >= RELAY_MIN_THIRDS))
                ? nxt_dly : 1'b0;
    nxt_sync  = restart;
    gate_last = 3'((4'h1 << eff.gate_length_select) - 4'h1);
    arm_req   = sw_arm | (pin_s2_ff[1] & ~arm_old_ff);
    nxt_gst   = gst_ff;
    nxt_gcnt  = gcnt_ff;
    unique case (gst_ff)
      GATE_IDLE: begin
        if (arm_req) begin
          nxt_gst = GATE_ARMED;
        end
      end
      GATE_ARMED: begin
        if (restart) begin
          nxt_gst  = GATE_OPEN;
          nxt_gcnt = 3'h0;
        end
      end
      GATE_OPEN: begin
        if (reload) begin
          nxt_gst = GATE_IDLE;
        end else if (restart) begin
          if (gcnt_ff == gate_last) begin
            nxt_gst = arm_req ? GATE_ARMED : GATE_IDLE;
          end else begin
            nxt_gcnt = gcnt_ff + 3'h1;
          end
        end
      end
      default: nxt_gst = GATE_IDLE;
    endcase
    nxt_gate = (nxt_gst == GATE_OPEN);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr_ff    <= SEED;
      rnd_ff   <= SEED;
      pos_ff   <= 20'h0;
      len_ff   <= 5'h0;
      gst_ff   <= GATE_IDLE;
      gcnt_ff  <= 3'h0;
      dly_ff   <= 1'b0;
      sync_ff  <= 1'b0;
      gate_ff  <= 1'b0;
      relay_ff <= 1'b0;
      short_ff <= 1'b0;
    end else if (ce) begin
      sr_ff    <= nxt_sr;
      rnd_ff   <= nxt_rnd;
      pos_ff   <= nxt_pos;
      len_ff   <= eff.len_sel;
      gst_ff   <= nxt_gst;
      gcnt_ff  <= nxt_gcnt;
      dly_ff   <= nxt_dly;
      sync_ff  <= nxt_sync;
      gate_ff  <= nxt_gate;
      relay_ff <= nxt_relay;
      short_ff <= pin_s2_ff[0];
    end
  end

  assign prbs_o             = sr_ff[0];
  assign delayed_o          = dly_ff;
  assign sync_o             = sync_ff;
  assign gate_o             = gate_ff;
  assign relay_o            = relay_ff;
  assign gate_reset_short_o = short_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_restart;
    ce && restart;
  endsequence

  a_bit_on_tick: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !tick && !reload) |=> $stable(prbs_o)) else $error("bit changed off tick");
  a_shift_chain: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && tick && !reload) |=> sr_ff[31:1] == $past(sr_ff[30:0]))
    else $error("stage chain broken");
  a_seed_nonzero: assert property (@(posedge aclk) disable iff (!aresetn)
    (!rnd_mode && !reload) |-> sr_ff[FB_STAGES-1:0] != 20'h0)
    else $error("feedback stages all zero");
  a_pos_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    (!rnd_mode && !reload) |-> pos_ff <= seq_last(eff.len_sel))
    else $error("position past length");
  a_delay_random: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && rnd_mode) |=> !delayed_o) else $error("delayed driven in random mode");
  a_tap_value: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !rnd_mode) |=> delayed_o == $past(tap_v)) else $error("delayed tap mismatch");
  a_relay_fast: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && period_thirds(eff.rate_sel) < RELAY_MIN_THIRDS) |=> !relay_o)
    else $error("relay moved at fast rate");
  a_sync_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    s_restart |=> sync_o && pos_ff == 20'h0) else $error("sync not at restart");
  a_gate_open_sync: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(gate_o) |-> sync_o) else $error("gate opened off restart");
  a_reset_short: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && pin_s2_ff[0]) |=> gate_reset_short_o) else $error("button not shorted");
endmodule // prbs_delay_gen

// >>> hdl/prbs_pkg.sv
// constants, types and helper functions of the delayed-tap sequence generator
package prbs_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS       = 5;
  localparam int US_CYCLES           = 1000 / CLK_PERIOD_NS;
  localparam int RELAY_MIN_PERIOD_MS = 100;
  localparam longint RELAY_MIN_THIRDS = longint'(RELAY_MIN_PERIOD_MS) * 1000 * 3;
  localparam logic [4:0] RATE_MAX    = 5'h11;
  // ---------------------------------------------------------------
  // lengths and stages
  // ---------------------------------------------------------------
  localparam int STAGES              = 32;
  localparam int FB_STAGES           = 20;
  localparam int MIN_N               = 4;
  localparam logic [4:0] LEN_RANDOM  = 5'h11;
  localparam logic [31:0] SEED       = 32'h0000_0001;
  localparam int TBL_DEPTH           = 2048;
  // ---------------------------------------------------------------
  // register map and fields
  // ---------------------------------------------------------------
  localparam logic [5:0] OFF_CTRL    = 6'h00;
  localparam logic [5:0] OFF_DELAY   = 6'h04;
  localparam logic [5:0] OFF_TABLE   = 6'h08;
  localparam logic [5:0] OFF_STATUS  = 6'h0c;
  localparam logic [5:0] OFF_POS     = 6'h10;
  localparam int CTRL_LEN_LSB        = 0;
  localparam int CTRL_RATE_LSB       = 8;
  localparam int CTRL_EXT_BIT        = 16;
  localparam int CTRL_GLEN_LSB       = 17;
  localparam int CTRL_ARM_BIT        = 24;
  localparam int DELAY_DIRECT_BIT    = 16;
  localparam int TABLE_IDX_LSB       = 16;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] DELAY_RST  = 32'h0001_0000;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [1:0] gate_length_select;
    logic       ext_clk;
    logic [4:0] rate_sel;
    logic [4:0] len_sel;
  } settings_t;

  typedef struct packed {
    logic       use_b;
    logic [4:0] stage_b;
    logic [4:0] stage_a;
  } tap_pair_t;

  typedef enum logic [2:0] {
    GATE_IDLE  = 3'b001,
    GATE_ARMED = 3'b010,
    GATE_OPEN  = 3'b100
  } gate_state_t;

  // clock period in thirds of a microsecond: 1, 3.33, 10, 33.3 us ...
  function automatic longint period_thirds(input logic [4:0] sel);
    longint p;
    p = sel[0] ? 64'd10 : 64'd3;
    for (int k = 0; k < 9; k++) begin
      if (k < int'(sel[4:1])) begin
        p = p * 10;
      end
    end
    return p;
  endfunction

  // maximal-length feedback taps, bit p-1 for stage p
  function automatic logic [FB_STAGES-1:0] tap_mask(input logic [4:0] sel);
    unique case (sel)
      5'h00:   return 20'h0000c;
      5'h01:   return 20'h00014;
      5'h02:   return 20'h00030;
      5'h03:   return 20'h00060;
      5'h04:   return 20'h000b8;
      5'h05:   return 20'h00110;
      5'h06:   return 20'h00240;
      5'h07:   return 20'h00500;
      5'h08:   return 20'h00e08;
      5'h09:   return 20'h01c80;
      5'h0a:   return 20'h03802;
      5'h0b:   return 20'h06000;
      5'h0c:   return 20'h0d008;
      5'h0d:   return 20'h12000;
      5'h0e:   return 20'h20400;
      5'h0f:   return 20'h72000;
      5'h10:   return 20'h90000;
      default: return 20'h00000;
    endcase
  endfunction

  function automatic logic [19:0] seq_last(input logic [4:0] sel);
    logic [20:0] one_hot;
    one_hot = 21'h1 << (sel + 5'(MIN_N));
    return 20'(one_hot - 21'h2);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage

// >>> hdl/prbs_tick_gen.sv
// sequence clock tick from internal rate divider or synchronised external clock
`timescale 1ns/100ps
module prbs_tick_gen
  import prbs_pkg::*;
#(
  parameter int UNIT_CYCLES = US_CYCLES
) (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  // selection
  input  wire logic [4:0] rate_sel,
  input  wire logic       ext_sel,
  input  wire logic       ext_clk_pin,
  // tick out
  output logic            tick
);
  logic [39:0] cnt_ff,  nxt_cnt;
  logic [2:0]  ext_ff,  nxt_ext;
  logic        tick_ff, nxt_tick;
  logic [39:0] last;
  logic [4:0]  sel;

  always_comb begin
    sel      = (rate_sel > RATE_MAX) ? RATE_MAX : rate_sel;
    last     = 40'(longint'(UNIT_CYCLES) * period_thirds(sel) / 3) - 40'h1;
    nxt_ext  = {ext_ff[1:0], ext_clk_pin};
    nxt_cnt  = cnt_ff + 40'h1;
    nxt_tick = 1'b0;
    if (ext_sel) begin
      nxt_cnt  = 40'h0;
      nxt_tick = ext_ff[1] & ~ext_ff[2];
    end else if (cnt_ff >= last) begin
      nxt_cnt  = 40'h0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff  <= 40'h0;
      ext_ff  <= 3'h0;
      tick_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff  <= nxt_cnt;
      ext_ff  <= nxt_ext;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;
endmodule // prbs_tick_gen

// >>> tb/prbs_correlator_model.sv
// gated correlator and integrator standing at the far side of the generator
`timescale 1ns/100ps
module prbs_correlator_model (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // generator outputs
  input  wire logic gate_in,
  input  wire logic seq_in,
  input  wire logic clear_in,
  // integrator value
  output int        acc
);
  // ----
  // plus or minus one product, summed only while gate open
  // ----
  always_ff @(posedge aclk) begin
    if (!aresetn || clear_in) begin
      acc <= 0;
    end else if (gate_in) begin
      acc <= seq_in ? acc + 1 : acc - 1;
    end
  end
endmodule // prbs_correlator_model

// >>> tb/prbs_delay_gen_bench.sv
// self-checking bench of the delayed-tap sequence generator
`timescale 1ns/100ps
module prbs_delay_gen_bench;
  import prbs_pkg::*;
  localparam int UC = 4;
  logic        aclk = '0, aresetn = '0, ce = '1;
  logic [5:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0]  wstrb = '0;
  logic        awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic        ext_clk_pin = '0, remote_sel = '0, remote_arm = '0, gate_reset_btn = '0;
  settings_t   remote_set = '0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        prbs_o, delayed_o, sync_o, gate_o, relay_o, gate_reset_short_o;
  int          acc, err_count = 0, n_checks = 0, ext_half = 0, ones, rly, ns, d, l;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  logic        p[2048];
  logic        q[2048];

  prbs_delay_gen #(.UNIT_CYCLES(UC)) dut (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .ext_clk_pin, .remote_sel, .remote_set, .remote_arm,
    .gate_reset_btn, .prbs_o, .delayed_o, .sync_o, .gate_o, .relay_o, .gate_reset_short_o);
  prbs_correlator_model model (.aclk, .aresetn, .gate_in(gate_o), .seq_in(delayed_o),
    .clear_in(gate_reset_short_o), .acc);

  always #2.5 aclk = ~aclk;

  always begin
    if (ext_half > 0) begin
      repeat (ext_half) @(posedge aclk);
      ext_clk_pin <= ~ext_clk_pin;
    end else begin
      @(posedge aclk);
    end
  end

  // ----
  // compare, bus tasks and response watcher
  // ----
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic axw(input logic [5:0] a, input logic [31:0] dv, input logic [3:0] s,
                     input logic [1:0] r);
    int t;
    t = 0;
    @(posedge aclk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= dv;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && t < 200);
    bready <= 1'b0;
    if (t >= 200) err_count++;
  endtask

  task automatic axr(input logic [5:0] a, input logic [31:0] e, input logic [1:0] r);
    int t;
    t = 0;
    @(posedge aclk);
    rq.push_back({r, e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && t < 200);
    rready <= 1'b0;
    if (t >= 200) err_count++;
  endtask

  always @(posedge aclk) begin
    if (bvalid && bready) begin
      chk("bresp", 32'(bq.pop_front()), 32'(bresp));
    end
    if (rvalid && rready) begin
      chk("rdata", rq[0][31:0], rdata);
      chk("rresp", 32'(rq[0][33:32]), 32'(rresp));
      void'(rq.pop_front());
    end
  end

  // ----
  // sequence capture, one sample per bit between two sync pulses
  // ----
  task automatic run_len(input int n, input int bp);
    int c;
    c = 0;
    ones = 0;
    rly = 0;
    while (sync_o !== 1'b1 && c < 40000) begin
      @(posedge aclk);
      c++;
    end
    c = 0;
    do begin
      @(posedge aclk);
      c++;
      if (c % bp == bp / 2 && c / bp < n) begin
        p[c / bp] = prbs_o;
        q[c / bp] = delayed_o;
        ones += int'(prbs_o === 1'b1);
        rly += int'(relay_o !== 1'b0);
      end
    end while (sync_o !== 1'b1 && c < 40000);
    chk("sync gap", 32'(n * bp), 32'(c));
  endtask

  task automatic chk_tap(input int n, input int a, input int b, input bit ub);
    int bad;
    bad = 0;
    for (int k = 0; k < n; k++) begin
      if (q[k] !== (p[(k - a % n + n) % n] ^ (ub & p[(k - b % n + n) % n]))) bad++;
    end
    chk("tap mismatches", 0, 32'(bad));
  endtask

  task automatic gate_run(input int g);
    int c;
    int w;
    c = 0;
    w = 0;
    gate_reset_btn <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("reset short", 1, 32'(gate_reset_short_o));
    chk("integrator cleared", 0, 32'(acc));
    gate_reset_btn <= 1'b0;
    axw(OFF_CTRL, (32'(g) << CTRL_GLEN_LSB) | (32'h1 << CTRL_ARM_BIT), 4'hf, RESP_OKAY);
    while (gate_o !== 1'b1 && c < 1000) begin
      @(posedge aclk);
      c++;
    end
    chk("sync with gate", 1, 32'(sync_o));
    while (gate_o === 1'b1 && w < 4000) begin
      @(posedge aclk);
      w++;
    end
    chk("gate span", 32'((1 << g) * 15 * UC), 32'(w));
    chk("integral", 32'(UC << g), 32'(acc));
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    err_count++;
    complete_run();
  end

  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(41066));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axr(OFF_CTRL, CTRL_RST, RESP_OKAY);
    axr(OFF_DELAY, DELAY_RST, RESP_OKAY);
    axr(6'h14, 32'h0, RESP_SLVERR);
    axw(6'h18, $urandom, 4'hf, RESP_SLVERR);
    axw(OFF_TABLE, 32'h0, 4'h3, RESP_OKAY);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      axw(OFF_CTRL, 32'(i), 4'hf, RESP_OKAY);
      run_len((1 << (i + 4)) - 1, UC);
      chk("ones", 32'(1 << (i + 3)), 32'(ones));
      chk_tap((1 << (i + 4)) - 1, 0, 0, 1'b0);
      chk("relay", 0, 32'(rly));
    end
    $display("test lengths done");
    axw(OFF_CTRL, 32'h0, 4'hf, RESP_OKAY);
    // let all 32 stages fill with sequence bits after the seed reload
    run_len(15, UC);
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 31 : int'($urandom_range(30));
      axw(OFF_DELAY, 32'h0001_0000 | 32'(d), 4'hf, RESP_OKAY);
      run_len(15, UC);
      chk_tap(15, d, 0, 1'b0);
    end
    $display("test direct delays done");
    axw(OFF_CTRL, 32'h2, 4'hf, RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      l = (i == 0) ? 0 : int'($urandom_range(31));
      d = (i == 0) ? 8 : int'($urandom_range(31));
      axw(OFF_TABLE, (32'(i) << TABLE_IDX_LSB) | 32'h400 | 32'(d << 5) | 32'(l), 4'hf,
          RESP_OKAY);
      axw(OFF_DELAY, 32'(i), 4'hf, RESP_OKAY);
      run_len(63, UC);
      chk_tap(63, l, d, 1'b1);
    end
    $display("test combined delays done");
    axw(OFF_DELAY, DELAY_RST, 4'hf, RESP_OKAY);
    axw(OFF_CTRL, 32'h1 << CTRL_EXT_BIT, 4'hf, RESP_OKAY);
    ext_half = 10;
    run_len(15, 20);
    ext_half = 0;
    $display("test external clock done");
    axw(OFF_CTRL, 32'h0, 4'hf, RESP_OKAY);
    for (int g = 0; g < 4; g++) begin
      gate_run(g);
    end
    $display("test gate done");
    axw(OFF_CTRL, 32'(LEN_RANDOM), 4'hf, RESP_OKAY);
    ones = 0;
    rly = 0;
    ns = 0;
    repeat (200) begin
      @(posedge aclk);
      ones += int'(prbs_o === 1'b1);
      rly += int'(delayed_o !== 1'b0);
      ns += int'(sync_o !== 1'b0);
    end
    chk("random delayed", 0, 32'(rly));
    chk("random sync", 0, 32'(ns));
    chk("random toggles", 1, 32'(ones > 0 && ones < 200));
    $display("test random mode done");
    l = int'($urandom_range(2));
    remote_set <= settings_t'(13'(l));
    remote_sel <= 1'b1;
    run_len((1 << (l + 4)) - 1, UC);
    chk("remote ones", 32'(1 << (l + 3)), 32'(ones));
    remote_arm <= 1'b1;
    ns = 0;
    while (gate_o !== 1'b1 && ns < 1000) begin
      @(posedge aclk);
      ns++;
    end
    chk("remote gate", 1, 32'(gate_o));
    chk("remote gate sync", 1, 32'(sync_o));
    $display("test remote done");
    complete_run();
  end
endmodule // prbs_delay_gen_bench
